/* File: hdl/stv_pkg.sv */
// Summary of operation
// - Each quadrature edge counts up or down: four counts per line.
// - Phase A, phase B and index pass a two-flop synchroniser first.
// - Armed capture copies position when A, B and index are all low.
// - Home switch low on index, when armed and with A and B low, records position and raises interrupt.
// - Position mode accelerates to max velocity or brakes to stop at target.
// - Deceleration uses the same magnitude as acceleration.
// - New velocity and target apply mid-move from the present state.
// - Velocity mode ramps to velocity and holds until a stop command.
// - Velocity mode advances desired position each sample regardless of motion.
// - Trajectory parameters are 32-bit; target is signed two's complement.
// - Velocity and acceleration are unsigned 16.16 fixed point.
// - Each sample adds acceleration to velocity until command velocity reached.
// - Each sample, error is desired minus actual position, sent downstream.
// - Sample interval is 341 us; units are counts per sample.
// - Host uses status/command byte port plus adjacent data byte port.
package stv_pkg;

  localparam int CLK_PERIOD_NS = 5;
  localparam int SAMPLE_US = 341;
  localparam int SAMPLE_CYCLES = SAMPLE_US * 1000 / CLK_PERIOD_NS;
  localparam int FRAC_BITS = 16;

  // Command bytes on the command port
  localparam logic [7:0] CMD_LOAD_TARGET = 8'h01;
  localparam logic [7:0] CMD_LOAD_VEL = 8'h02;
  localparam logic [7:0] CMD_LOAD_ACC = 8'h03;
  localparam logic [7:0] CMD_START_POS = 8'h04;
  localparam logic [7:0] CMD_START_VEL = 8'h05;
  localparam logic [7:0] CMD_STOP = 8'h06;
  localparam logic [7:0] CMD_ARM_INDEX = 8'h07;
  localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h08;
  localparam logic [7:0] CMD_READ_INDEX = 8'h09;
  localparam logic [7:0] CMD_READ_POS = 8'h0a;

  // Status byte bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_INDEX = 1;
  localparam int ST_DONE = 2;
  localparam int ST_ARMED = 3;

  localparam logic [1:0] BYTE_LAST = 2'h3;
  localparam logic [31:0] RESET_VEL = 32'h0;
  localparam logic [31:0] RESET_ACC = 32'h0;

  typedef enum logic [1:0] {
    STV_IDLE = 2'b00,
    STV_POS = 2'b01,
    STV_VEL = 2'b10,
    STV_STOP = 2'b11
  } stv_mode_type;

  typedef struct packed {
    logic a;
    logic b;
    logic idx;
  } stv_enc_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic sel_data;
    logic [7:0] data;
  } stv_port_type;

  typedef struct packed {
    logic valid;
    logic [31:0] error;
  } stv_err_type;

endpackage : stv_pkg

/* File: hdl/stv_quad_decoder.sv */
`timescale 1ns/1ps
module stv_quad_decoder
  import stv_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire stv_enc_type i_enc,
  output logic [31:0] o_count,
  output logic o_all_low
);

  typedef struct packed {
    stv_enc_type meta;
    stv_enc_type sync;
    stv_enc_type prev;
    logic [31:0] count;
    logic all_low;
    logic [1:0] fill;
  } stv_qd_state_type;

  stv_qd_state_type st_q;
  stv_qd_state_type st_d;
  logic ch_a;
  logic ch_b;

  // Count update from the synchronised phases only
  always_comb begin
    st_d = st_q;
    st_d.meta = i_enc;
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;
    ch_a = st_q.sync.a ^ st_q.prev.a;
    ch_b = st_q.sync.b ^ st_q.prev.b;
    // Warm-up: no edge until the history holds real pin levels
    if (st_q.fill != '1) begin
      st_d.fill = st_q.fill + 2'h1;
    end
    // double change ignored
    // Both phases flipping is an illegal jump; no count is better than a
    // guessed one.
    if (ch_a != ch_b && st_q.fill == '1) begin
      // Direction from old A against new B
      if (st_q.prev.a ^ st_q.sync.b) begin
        st_d.count = st_q.count + 32'h1;
      end else begin
        st_d.count = st_q.count - 32'h1;
      end
    end
    st_d.all_low = ~(st_q.sync.a | st_q.sync.b | st_q.sync.idx);
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_q <= '0;
      // Index idles high; a low flush would fake an all-low onset
      st_q.meta.idx <= 1'b1;
      st_q.sync.idx <= 1'b1;
      st_q.prev.idx <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_count = st_q.count;
  assign o_all_low = st_q.all_low;

endmodule : stv_quad_decoder

/* File: hdl/stv_servo_core.sv */
`timescale 1ns/1ps
module stv_servo_core
  import stv_pkg::*;
#(
  parameter int SAMPLE_CNT = SAMPLE_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire stv_enc_type i_enc,
  input wire stv_port_type i_port,
  output logic [7:0] o_port_rdata,
  output stv_err_type o_err,
  output logic [31:0] o_desired_pos,
  output logic o_index_irq
);

  localparam int TW = $clog2(SAMPLE_CNT + 1);

  if (SAMPLE_CNT < 2) begin : g_chk
    $error("SAMPLE_CNT must be at least 2");
  end

  typedef struct packed {
    stv_mode_type mode;
    logic [31:0] target;
    logic [31:0] vmax;
    logic [31:0] acc;
    logic [47:0] pos;
    logic [31:0] vel;
    logic dir;
    logic [TW-1:0] tick;
    logic [7:0] cmd;
    logic [31:0] wshift;
    logic [1:0] wcnt;
    logic [31:0] rshift;
    logic [7:0] rdata;
    logic [31:0] index_pos;
    logic armed;
    logic index_flag;
    logic done_flag;
    logic low_prev;
    stv_err_type err;
  } stv_state_type;

  stv_state_type st_q;
  stv_state_type st_d;
  logic [31:0] act_pos;
  logic all_low;
  logic [32:0] diff;
  logic [31:0] dist_abs;
  logic want_dir;
  logic [95:0] vsq;
  logic [95:0] brake_room;
  logic brake;
  logic [31:0] pos_int;
  logic [31:0] vel_n;
  logic [47:0] step;
  logic capture;
  logic mv_dir;

  // Move speed one acceleration step toward lim, never past it
  function automatic logic [31:0] stv_ramp(input logic [31:0] v,
                                           input logic [31:0] a,
                                           input logic [31:0] lim);
    logic [32:0] up;
    up = {1'b0, v} + {1'b0, a};
    if (v < lim) begin
      stv_ramp = (up > {1'b0, lim}) ? lim : up[31:0];
    end else if (v - lim > a) begin
      stv_ramp = v - a;
    end else begin
      stv_ramp = lim;
    end
  endfunction : stv_ramp

  stv_quad_decoder u_dec (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_enc(i_enc),
    .o_count(act_pos),
    .o_all_low(all_low)
  );

  always_comb begin
    st_d = st_q;
    st_d.err.valid = 1'b0;
    pos_int = st_q.pos[47:FRAC_BITS];
    diff = {st_q.target[31], st_q.target} - {pos_int[31], pos_int};
    want_dir = ~diff[32];
    dist_abs = diff[32] ? 32'(-diff) : diff[31:0];
    // Stop distance test v^2 >= 2*a*d, all in 16.16 terms
    // Full-width square; a 32-bit product would wrap and never brake
    vsq = 96'(st_q.vel) * 96'(st_q.vel);
    brake_room = (96'(st_q.acc) * 96'(dist_abs)) << (FRAC_BITS + 1);
    brake = vsq >= brake_room;
    vel_n = st_q.vel;
    step = 48'h0;
    capture = 1'b0;
    mv_dir = st_q.dir;

    // Host byte port: command/status and data
    // byte port
    if (i_port.wr && !i_port.sel_data) begin
      st_d.cmd = i_port.data;
      st_d.wcnt = 2'h0;
      case (i_port.data)
        CMD_START_POS: begin
          st_d.mode = STV_POS;
          st_d.done_flag = 1'b0;
        end
        CMD_START_VEL: begin
          st_d.mode = STV_VEL;
          st_d.done_flag = 1'b0;
        end
        CMD_STOP: begin
          if (st_q.mode != STV_IDLE) begin
            st_d.mode = STV_STOP;
          end
        end
        CMD_ARM_INDEX: st_d.armed = 1'b1;
        CMD_CLEAR_FLAGS: begin
          st_d.index_flag = 1'b0;
          st_d.done_flag = 1'b0;
        end
        CMD_READ_INDEX: st_d.rshift = st_q.index_pos;
        CMD_READ_POS: st_d.rshift = act_pos;
        default: st_d.cmd = i_port.data;
      endcase
    end
    // Data bytes arrive most significant first
    if (i_port.wr && i_port.sel_data) begin
      st_d.wshift = {st_q.wshift[23:0], i_port.data};
      st_d.wcnt = st_q.wcnt + 2'h1;
      if (st_q.wcnt == BYTE_LAST) begin
        case (st_q.cmd)
          CMD_LOAD_TARGET: st_d.target = st_d.wshift;
          CMD_LOAD_VEL: st_d.vmax = st_d.wshift;
          CMD_LOAD_ACC: st_d.acc = st_d.wshift;
          default: st_d.wcnt = 2'h0;
        endcase
      end
    end
    if (i_port.rd) begin
      if (i_port.sel_data) begin
        st_d.rdata = st_q.rshift[31:24];
        st_d.rshift = {st_q.rshift[23:0], 8'h00};
      end else begin
        st_d.rdata = '0;
        st_d.rdata[ST_BUSY] = st_q.mode != STV_IDLE;
        st_d.rdata[ST_INDEX] = st_q.index_flag;
        st_d.rdata[ST_DONE] = st_q.done_flag;
        st_d.rdata[ST_ARMED] = st_q.armed;
      end
    end

    // Index / home capture on the all-low onset; a set beats a clear
    st_d.low_prev = all_low;
    if (all_low && !st_q.low_prev && st_q.armed) begin
      capture = 1'b1;
    end
    if (capture) begin
      st_d.index_pos = act_pos;
      st_d.armed = 1'b0;
      st_d.index_flag = 1'b1;
    end

    if (st_q.tick == TW'(SAMPLE_CNT - 1)) begin
      st_d.tick = '0;
    end else begin
      st_d.tick = st_q.tick + TW'(1);
    end

    if (st_q.tick == '0) begin
      case (st_q.mode)
        STV_POS: begin
          // From rest the move heads straight for the target
          if (st_q.vel == '0) begin
            mv_dir = want_dir;
          end
          if ((mv_dir != want_dir && st_q.vel != '0) || brake) begin
            vel_n = stv_ramp(st_q.vel, st_q.acc, 32'h0);
          end else begin
            vel_n = stv_ramp(st_q.vel, st_q.acc, st_q.vmax);
          end
          step = {16'h0, vel_n};
          // Snap onto target instead of overshooting the last fraction
          if (mv_dir == want_dir && {dist_abs, 16'h0} <= step) begin
            st_d.pos = {st_q.target, 16'h0};
            vel_n = '0;
            step = '0;
            st_d.mode = STV_IDLE;
            st_d.done_flag = 1'b1;
          end
        end
        STV_VEL: begin
          // Unsigned velocity runs forward; a reverse move brakes first
          if (st_q.vel == '0) begin
            mv_dir = 1'b1;
          end
          if (mv_dir) begin
            vel_n = stv_ramp(st_q.vel, st_q.acc, st_q.vmax);
          end else begin
            vel_n = stv_ramp(st_q.vel, st_q.acc, 32'h0);
          end
          step = {16'h0, vel_n};
        end
        STV_STOP: begin
          vel_n = stv_ramp(st_q.vel, st_q.acc, 32'h0);
          step = {16'h0, vel_n};
          if (vel_n == '0) begin
            st_d.mode = STV_IDLE;
            st_d.done_flag = 1'b1;
          end
        end
        default: vel_n = '0;
      endcase
      st_d.vel = vel_n;
      st_d.dir = mv_dir;
      // advance blindly
      // Actual motion is never consulted, so a stalled rotor lets the
      // error grow without bound; watching it is the host's job.
      if (step != '0) begin
        st_d.pos = mv_dir ? st_q.pos + step : st_q.pos - step;
      end
      st_d.err.valid = 1'b1;
      st_d.err.error = st_d.pos[47:FRAC_BITS] - act_pos;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_q <= '0;
      st_q.mode <= STV_IDLE;
      st_q.acc <= RESET_ACC;
      st_q.vmax <= RESET_VEL;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_port_rdata = st_q.rdata;
  assign o_err = st_q.err;
  assign o_desired_pos = st_q.pos[47:FRAC_BITS];
  assign o_index_irq = st_q.index_flag;

endmodule : stv_servo_core

/* File: tb/stv_monitor.sv */
`timescale 1ns/1ps
module stv_monitor
  import stv_pkg::*;
#(
  parameter int SAMPLE_CNT = SAMPLE_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire stv_enc_type i_enc,
  input wire stv_port_type i_port,
  input wire logic [7:0] o_port_rdata,
  input wire stv_err_type o_err,
  input wire logic [31:0] o_desired_pos,
  input wire logic o_index_irq
);
  logic [31:0] gap_q;
  logic seen_q;
  logic clr;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // Flag clear command on the command port
  assign clr = i_port.wr && !i_port.sel_data && i_port.data == CMD_CLEAR_FLAGS;
  // Cycles since the last sample pulse
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      gap_q <= 32'h0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= o_err.valid ? 32'h1 : gap_q + 32'h1;
      seen_q <= seen_q | o_err.valid;
    end
  end
  sequence s_pulse;
    o_err.valid ##1 !o_err.valid;
  endsequence
  sequence s_clr_cmd;
    clr;
  endsequence
  a_err_period: assert property (
    o_err.valid && seen_q |-> gap_q == SAMPLE_CNT) else $error("bad spacing");
  a_err_pulse: assert property (
    o_err.valid |-> s_pulse) else $error("sample pulse too long");
  a_err_hold: assert property (
    !o_err.valid |-> $stable(o_err.error)) else $error("error moved");
  a_first_tick: assert property (
    $rose(i_nrst) |-> ##[0:2] o_err.valid) else $error("no first sample");
  a_pos_sample: assert property (
    $changed(o_desired_pos) |-> (##[0:2] o_err.valid) or
    ($past(o_err.valid) || $past(o_err.valid, 2))) else $error("pos off tick");
  a_rdata_hold: assert property (
    $changed(o_port_rdata) |-> $past(i_port.rd)) else $error("rdata moved");
  a_irq_cause: assert property (
    $rose(o_index_irq) |-> $past(i_enc, 3) == 3'h0) else $error("bad capture");
  a_irq_clear: assert property (
    s_clr_cmd |-> ##[1:2] !o_index_irq) else $error("flag not cleared");
  a_irq_sticky: assert property (
    $fell(o_index_irq) |-> $past(clr) || $past(clr, 2)) else $error("flag lost");
endmodule : stv_monitor

bind stv_servo_core stv_monitor #(.SAMPLE_CNT(SAMPLE_CNT)) mon_u (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_enc(i_enc), .i_port(i_port),
  .o_port_rdata(o_port_rdata), .o_err(o_err),
  .o_desired_pos(o_desired_pos), .o_index_irq(o_index_irq));

/* File: tb/stv_host_model.sv */
`timescale 1ns/1ps
module stv_host_model
  import stv_pkg::*;
(
  input wire logic i_clock,
  output stv_port_type o_port
);
  // Idle bus after a write shows the inverse of the written byte; a read strobe inverts the bus byte again
  initial o_port = '{1'b0, 1'b0, 1'b0, 8'ha5};
  task automatic put(input logic sel, input logic [7:0] b);
    @(negedge i_clock);
    o_port <= '{1'b1, 1'b0, sel, b};
    @(negedge i_clock);
    o_port <= '{1'b0, 1'b0, sel, ~b};
  endtask : put
  task automatic get(input logic sel);
    @(negedge i_clock);
    o_port <= '{1'b0, 1'b1, sel, ~o_port.data};
    @(negedge i_clock);
    o_port.rd <= 1'b0;
  endtask : get
  // command, then four data bytes high first
  task automatic load(input logic [7:0] cmd, input logic [31:0] w);
    put(1'b0, cmd);
    for (int i = 3; i >= 0; i--) put(1'b1, w[8*i +: 8]);
  endtask : load
endmodule : stv_host_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top import stv_pkg::*;;
  localparam int SCNT = 16;
  logic i_clock;
  logic i_nrst;
  stv_enc_type i_enc;
  stv_port_type port;
  logic [7:0] rdata;
  stv_err_type err;
  logic [31:0] dpos;
  logic irq;
  logic rd_q = 1'b0;
  logic [31:0] pd, pe, dd, de;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'hc284;
  int ph = 0;
  int cnt = 0;
  int mx = 0;
  int ls = 0;
  stv_servo_core #(.SAMPLE_CNT(SCNT)) dut_u (.i_clock(i_clock),
    .i_nrst(i_nrst), .i_enc(i_enc), .i_port(port), .o_port_rdata(rdata),
    .o_err(err), .o_desired_pos(dpos), .o_index_irq(irq));
  stv_host_model host_u (.i_clock(i_clock), .o_port(port));
  // 200 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  task automatic summarize();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  // Hang guard, far above the whole sequence
  always @(posedge i_clock) begin
    rd_q <= port.rd;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  // Read byte settles the cycle after the strobe; oldest note first
  always @(negedge i_clock) begin
    if (rd_q && exp_q.size() == 0) check("read queue", 32'h1, 32'h0);
    else if (rd_q) check("read byte", rdata, exp_q.pop_front());
  end
  // Shaft moves d phase steps; a jump of two must not count
  task automatic step(input int d);
    ph = (ph + d) & 3;
    cnt += (d == 2) ? 0 : d;
    @(negedge i_clock);
    i_enc.a <= ph[1];
    i_enc.b <= ph[1] ^ ph[0];
    repeat (4) @(negedge i_clock);
  endtask : step
  task automatic pulse_idx();
    @(negedge i_clock);
    i_enc.idx <= 1'b0;
    repeat (8) @(negedge i_clock);
    i_enc.idx <= 1'b1;
    repeat (8) @(negedge i_clock);
  endtask : pulse_idx
  task automatic rd_word(input logic [7:0] cmd, input logic [31:0] w);
    host_u.put(1'b0, cmd);
    for (int i = 3; i >= 0; i--) begin
      exp_q.push_back(w[8*i +: 8]);
      host_u.get(1'b1);
    end
  endtask : rd_word
  task automatic rd_stat(input logic [7:0] s);
    exp_q.push_back(s);
    host_u.get(1'b0);
  endtask : rd_stat
  // Waits n samples, keeping the last deltas and the largest step
  task automatic samples(input int n);
    int w;
    for (int k = 0; k < n; k++) begin
      pd = dpos;
      pe = err.error;
      w = 0;
      while (err.valid !== 1'b1 && w < 100) begin
        @(negedge i_clock);
        w++;
      end
      repeat (3) @(negedge i_clock);
      dd = dpos - pd;
      de = err.error - pe;
      if ($signed(dd) < 0 && -dd > mx) mx = -dd;
      if ($signed(dd) > 0 && dd > mx) mx = dd;
      // Last nonzero step shows whether the move braked at the end
      if (dd != 0) ls = ($signed(dd) < 0) ? -dd : dd;
    end
  endtask : samples
  initial begin
    i_nrst = 1'b0;
    i_enc = 3'h1;
    repeat (3) @(negedge i_clock);
    i_nrst <= 1'b1;
    @(negedge i_clock);
    pulse_idx();
    check("irq unarmed", {31'h0, irq}, 32'h0);
    repeat (40) step(($random(seed) & 3) - 1);
    rd_word(CMD_READ_POS, cnt);
    while (ph != 0) step(1);
    host_u.put(1'b0, CMD_ARM_INDEX);
    rd_stat(8'h08);
    pulse_idx();
    check("irq set", {31'h0, irq}, 32'h1);
    rd_stat(8'h02);
    rd_word(CMD_READ_INDEX, cnt);
    repeat (4) step(1);
    host_u.put(1'b0, CMD_CLEAR_FLAGS);
    repeat (3) @(negedge i_clock);
    check("irq clear", {31'h0, irq}, 32'h0);
    // Rates scaled by 65536; target is -300 then -120
    host_u.load(CMD_LOAD_ACC, 32'h0001_0000);
    host_u.load(CMD_LOAD_VEL, 32'h0005_0000);
    host_u.load(CMD_LOAD_TARGET, 32'hffff_fed4);
    host_u.put(1'b0, CMD_START_POS);
    samples(10);
    host_u.load(CMD_LOAD_TARGET, 32'hffff_ff88);
    samples(50);
    check("peak step", mx, 32'h5);
    check("final pos", dpos, 32'hffff_ff88);
    check("final err", err.error, 32'hffff_ff88 - cnt);
    check("last step", ls, 32'h1);
    rd_stat(8'h04);
    host_u.load(CMD_LOAD_VEL, 32'h0003_0000);
    host_u.put(1'b0, CMD_START_VEL);
    samples(12);
    check("vel step", dd, 32'h3);
    check("err growth", de, 32'h3);
    rd_stat(8'h01);
    host_u.put(1'b0, CMD_STOP);
    samples(12);
    check("stopped", dd, 32'h0);
    summarize();
  end
endmodule : tb_top
